// File: core/emb_pkg.sv
package emb_pkg;

  // Array geometry: 2048 bits held as 128 rows of the widest word.
  localparam int MAX_W = 16;
  localparam int ADDR_W = 11;
  localparam int ROW_W = 7;
  localparam int ROWS = 128;
  localparam int LANE_W = 4;
  localparam int SHAPE_W = 3;
  localparam int MODE_W = 3;

  // Register byte offsets on the APB side.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_LOAD_ADDR = 12'h008;
  localparam logic [11:0] OFS_LOAD_DATA = 12'h00C;
  localparam logic [11:0] OFS_CFG_DONE = 12'h010;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SHAPE_LSB = 4;
  localparam int CTRL_LOWPWR_BIT = 8;
  localparam int CTRL_PWRDN_BIT = 9;

  // Status register fields.
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_CFG_BIT = 1;
  localparam int STAT_PWRDN_BIT = 2;
  localparam int STAT_LOWPWR_BIT = 3;
  localparam int STAT_ADDR_LSB = 16;

  // Organisations: code n gives words of 16 >> n bits.
  localparam logic [SHAPE_W-1:0] SHAPE_128X16 = 3'h0;
  localparam logic [SHAPE_W-1:0] SHAPE_2048X1 = 3'h4;

  typedef enum logic [MODE_W-1:0] {
    EMB_SP_RAM = 3'h0,
    EMB_ROM = 3'h1,
    EMB_DP_RW = 3'h2,
    EMB_DP_IO = 3'h3,
    EMB_CAM = 3'h4
  } emb_mode_e;

  // Reset values of the control fields.
  localparam emb_mode_e MODE_RST = EMB_SP_RAM;
  localparam logic [SHAPE_W-1:0] SHAPE_RST = SHAPE_128X16;
  localparam logic LOWPWR_RST = 1'b0;
  localparam logic PWRDN_RST = 1'b1;

  // Extra clk_sys cycles that low-power operation adds to an output update.
  localparam int LP_EXTRA_DEF = 2;

endpackage

// File: core/emb_memory_block.sv
module emb_memory_block #(
  parameter int LP_EXTRA = emb_pkg::LP_EXTRA_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr_local,
  input wire logic clr_global,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inclock,
  input wire logic outclock,
  input wire logic inclken,
  input wire logic outclken,
  input wire logic wren,
  input wire logic [emb_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [emb_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [emb_pkg::MAX_W-1:0] data_in,
  output logic [emb_pkg::MAX_W-1:0] data_out,
  output logic match_out
);
  import emb_pkg::*;

  if (LP_EXTRA < 2 || LP_EXTRA > 8) begin : g_bad_lp
    $error("LP_EXTRA must lie between 2 and 8.");
  end

  localparam int LP_CHK = LP_EXTRA;

  function automatic logic [MAX_W-1:0] width_mask(input logic [SHAPE_W-1:0] s);
    unique case (s)
      3'h0: return 16'hFFFF;
      3'h1: return 16'h00FF;
      3'h2: return 16'h000F;
      3'h3: return 16'h0003;
      default: return 16'h0001;
    endcase
  endfunction

  function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] a,
                                              input logic [SHAPE_W-1:0] s);
    logic [ADDR_W-1:0] t;
    t = a >> s;
    return t[ROW_W-1:0];
  endfunction

  function automatic logic [LANE_W-1:0] lane_of(input logic [ADDR_W-1:0] a,
                                                input logic [SHAPE_W-1:0] s);
    logic [ADDR_W-1:0] t;
    t = a & ((11'h001 << s) - 11'h001);
    return t[LANE_W-1:0];
  endfunction

  function automatic logic [LANE_W-1:0] lane_off(input logic [LANE_W-1:0] l,
                                                 input logic [SHAPE_W-1:0] s);
    return l << (3'h4 - s);
  endfunction

  function automatic logic [MAX_W-1:0] word_get(input logic [MAX_W-1:0] row,
                                                input logic [LANE_W-1:0] l,
                                                input logic [SHAPE_W-1:0] s);
    return (row >> lane_off(l, s)) & width_mask(s);
  endfunction

  function automatic logic [MAX_W-1:0] word_put(input logic [MAX_W-1:0] row,
                                                input logic [LANE_W-1:0] l,
                                                input logic [SHAPE_W-1:0] s,
                                                input logic [MAX_W-1:0] v);
    logic [MAX_W-1:0] m;
    m = width_mask(s) << lane_off(l, s);
    return (row & ~m) | ((v & width_mask(s)) << lane_off(l, s));
  endfunction

  // Configuration state, reset synchronously.
  emb_mode_e mode_reg;
  logic [SHAPE_W-1:0] shape_reg;
  logic lowpwr_reg;
  logic pwrdn_reg;
  logic cfg_done_reg;
  logic [ROW_W-1:0] load_addr_reg;
  logic [31:0] prdata_reg;

  // Data path registers, cleared asynchronously.
  logic inclock_prev_reg;
  logic outclock_prev_reg;
  logic [ADDR_W-1:0] waddr_in_reg;
  logic [ADDR_W-1:0] raddr_in_reg;
  logic [MAX_W-1:0] din_reg;
  logic wr_pulse_reg;
  logic [MAX_W-1:0] hold_reg;
  logic match_hold_reg;
  logic [LP_EXTRA-1:0] lp_pipe_reg;
  logic [MAX_W-1:0] data_out_reg;
  logic match_reg;

  logic [MAX_W-1:0] mem_reg [0:ROWS-1];

  wire clr_any = rst | clr_local | clr_global;
  wire active = cfg_done_reg & ~pwrdn_reg;
  wire in_rise = inclock & ~inclock_prev_reg;
  wire out_rise = outclock & ~outclock_prev_reg;
  wire in_strobe = in_rise & inclken & active;
  wire out_strobe = out_rise & outclken & active;
  wire can_write = (mode_reg != EMB_ROM);
  wire lp_pub = lp_pipe_reg[LP_EXTRA-1];

  // APB decode.
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_load_addr = (paddr == OFS_LOAD_ADDR);
  wire hit_load_data = (paddr == OFS_LOAD_DATA);
  wire hit_cfg = (paddr == OFS_CFG_DONE);
  wire addr_ok = hit_ctrl | hit_status | hit_load_addr | hit_load_data | hit_cfg;
  wire [MODE_W-1:0] wmode = pwdata[CTRL_MODE_LSB +: MODE_W];
  wire [SHAPE_W-1:0] wshape = pwdata[CTRL_SHAPE_LSB +: SHAPE_W];
  wire ctrl_bad = (wmode > EMB_CAM) | (wshape > SHAPE_2048X1);
  wire wr_err = hit_status | cfg_done_reg | (hit_ctrl & ctrl_bad);
  wire apb_err = ~addr_ok | (pwrite & wr_err);
  wire apb_wr_ok = apb_access & pwrite & ~apb_err;
  wire load_we = apb_wr_ok & hit_load_data;

  assign pready = 1'b1;
  assign pslverr = apb_access & apb_err;
  assign prdata = prdata_reg;
  assign data_out = data_out_reg;
  assign match_out = match_reg;

  // Read address per mode; dual-port read-write takes rd_addr at the outclock edge, dual-port input-output uses rd_addr captured on inclock.
  wire [ADDR_W-1:0] rd_src =
    (mode_reg == EMB_DP_RW) ? rd_addr :
    (mode_reg == EMB_DP_IO) ? raddr_in_reg :
    waddr_in_reg;
  wire [ROW_W-1:0] rd_row = row_of(rd_src, shape_reg);
  wire [LANE_W-1:0] rd_lane = lane_of(rd_src, shape_reg);
  wire [ROW_W-1:0] wr_row = row_of(waddr_in_reg, shape_reg);
  wire [LANE_W-1:0] wr_lane = lane_of(waddr_in_reg, shape_reg);
  wire [MAX_W-1:0] key = din_reg & width_mask(shape_reg);
  wire [4:0] lanes = 5'h01 << shape_reg;

  logic cam_hit;
  logic [ADDR_W-1:0] cam_addr;

  // Every stored word is compared at once; the lowest matching address wins.
  always_comb begin
    cam_hit = 1'b0;
    cam_addr = '0;
    for (int r = ROWS - 1; r >= 0; r--) begin
      for (int l = MAX_W - 1; l >= 0; l--) begin
        if (5'(l) < lanes && word_get(mem_reg[r], LANE_W'(l), shape_reg) == key) begin
          cam_hit = 1'b1;
          cam_addr = (ADDR_W'(r) << shape_reg) | ADDR_W'(l);
        end
      end
    end
  end

  wire [MAX_W-1:0] rd_value = (mode_reg == EMB_CAM) ? {5'h00, cam_addr}
                                                    : word_get(mem_reg[rd_row], rd_lane, shape_reg);

  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_MODE_LSB +: MODE_W] = mode_reg;
    ctrl_word[CTRL_SHAPE_LSB +: SHAPE_W] = shape_reg;
    ctrl_word[CTRL_LOWPWR_BIT] = lowpwr_reg;
    ctrl_word[CTRL_PWRDN_BIT] = pwrdn_reg;
    status_word = '0;
    status_word[STAT_MATCH_BIT] = match_reg;
    status_word[STAT_CFG_BIT] = cfg_done_reg;
    status_word[STAT_PWRDN_BIT] = pwrdn_reg;
    status_word[STAT_LOWPWR_BIT] = lowpwr_reg;
    status_word[STAT_ADDR_LSB +: ADDR_W] = cam_addr;
  end

  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_status ? status_word :
                       hit_load_addr ? {25'h000_0000, load_addr_reg} :
                       hit_load_data ? {16'h0000, mem_reg[load_addr_reg]} :
                       32'h0000_0000;

  // Shape, mode and power are fixed once configuration is declared done.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_reg <= MODE_RST;
      shape_reg <= SHAPE_RST;
      lowpwr_reg <= LOWPWR_RST;
      pwrdn_reg <= PWRDN_RST;
      cfg_done_reg <= 1'b0;
      load_addr_reg <= '0;
      prdata_reg <= '0;
    end else begin
      if (apb_setup) begin
        prdata_reg <= rd_mux;
      end
      if (apb_wr_ok && hit_ctrl) begin
        mode_reg <= emb_mode_e'(wmode);
        shape_reg <= wshape;
        lowpwr_reg <= pwdata[CTRL_LOWPWR_BIT];
        pwrdn_reg <= pwdata[CTRL_PWRDN_BIT];
      end
      if (apb_wr_ok && hit_load_addr) begin
        load_addr_reg <= pwdata[ROW_W-1:0];
      end else if (load_we) begin
        load_addr_reg <= load_addr_reg + 7'h01;
      end
      if (apb_wr_ok && hit_cfg && pwdata[0]) begin
        cfg_done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (load_we) begin
      mem_reg[load_addr_reg] <= pwdata[MAX_W-1:0];
    end else if (wr_pulse_reg) begin
      mem_reg[wr_row] <= word_put(mem_reg[wr_row], wr_lane, shape_reg, din_reg);
    end
  end

  always_ff @(posedge clk_sys or posedge clr_any) begin
    if (clr_any) begin
      inclock_prev_reg <= 1'b0;
      outclock_prev_reg <= 1'b0;
      waddr_in_reg <= '0;
      raddr_in_reg <= '0;
      din_reg <= '0;
      wr_pulse_reg <= 1'b0;
      hold_reg <= '0;
      match_hold_reg <= 1'b0;
      lp_pipe_reg <= '0;
      data_out_reg <= '0;
      match_reg <= 1'b0;
    end else begin
      inclock_prev_reg <= inclock;
      outclock_prev_reg <= outclock;
      if (in_strobe) begin
        waddr_in_reg <= wr_addr;
        raddr_in_reg <= rd_addr;
        din_reg <= data_in;
      end
      wr_pulse_reg <= in_strobe & wren & can_write;
      lp_pipe_reg <= {lp_pipe_reg[LP_EXTRA-2:0], out_strobe & lowpwr_reg};
      if (out_strobe) begin
        hold_reg <= rd_value;
        match_hold_reg <= (mode_reg == EMB_CAM) & cam_hit;
      end
      if (pwrdn_reg) begin
        data_out_reg <= '0;
        match_reg <= 1'b0;
      end else if (out_strobe && !lowpwr_reg) begin
        data_out_reg <= rd_value;
        match_reg <= (mode_reg == EMB_CAM) & cam_hit;
      end else if (lp_pub) begin
        data_out_reg <= hold_reg;
        match_reg <= match_hold_reg;
      end
    end
  end

  default clocking dflt_cb @(posedge clk_sys);
  endclocking
  default disable iff (clr_any);

  wr_single_a: assert property (
    wr_pulse_reg |=> !wr_pulse_reg
  ) else $error("Write pulse lasted more than one cycle.");

  in_capture_a: assert property (
    in_strobe |=> din_reg == $past(data_in) && waddr_in_reg == $past(wr_addr)
  ) else $error("Input registers missed an enabled input clock edge.");

  in_hold_a: assert property (
    !inclken |=> $stable(din_reg) && !wr_pulse_reg
  ) else $error("Input registers moved while the input enable was low.");

  rom_lock_a: assert property (
    mode_reg == EMB_ROM |-> !wr_pulse_reg
  ) else $error("Fabric write pulse in read-only mode.");

  cfg_lock_a: assert property (
    apb_access && pwrite && cfg_done_reg |-> pslverr ##1 ($stable(shape_reg) && $stable(mode_reg))
  ) else $error("Configuration changed after configuration was done.");

  cam_flag_a: assert property (
    out_strobe && mode_reg == EMB_CAM && !lowpwr_reg |=> match_reg == $past(cam_hit)
  ) else $error("Match flag disagrees with the search result.");

  cam_addr_a: assert property (
    out_strobe && mode_reg == EMB_CAM && !lowpwr_reg && cam_hit
      |=> data_out_reg == {5'h00, $past(cam_addr)}
  ) else $error("Search did not return the matching address.");

  hs_read_a: assert property (
    out_strobe && !lowpwr_reg && mode_reg != EMB_CAM |=> data_out_reg == $past(rd_value)
  ) else $error("High-speed read did not appear one cycle after the clock edge.");

  lp_delay_a: assert property (
    out_strobe && lowpwr_reg |-> !lp_pub ##[LP_CHK:LP_CHK] lp_pub
  ) else $error("Low-power output update was not delayed by the fixed amount.");

  pwrdn_a: assert property (
    pwrdn_reg && $past(pwrdn_reg) |-> data_out_reg == '0 && !match_reg && !wr_pulse_reg
  ) else $error("Powered-down instance showed activity.");

  cfg_hold_a: assert property (
    cfg_done_reg |=> cfg_done_reg
  ) else $error("Configuration done flag fell without a reset.");

  refuse_a: assert property (
    apb_access && pwrite && pslverr |=> $stable(load_addr_reg) && $stable(cfg_done_reg)
  ) else $error("A refused register write changed state.");

  lp_quiet_a: assert property (
    out_strobe && lowpwr_reg && !lp_pub |=> $stable(data_out_reg) && $stable(match_reg)
  ) else $error("Low-power output updated without the added delay.");

  clear_a: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    clr_any |-> data_out_reg == '0 && !match_reg && !wr_pulse_reg && din_reg == '0
  ) else $error("Registers not cleared while a clear was asserted.");

endmodule

// File: verification/emb_fabric_model.sv
module emb_fabric_model (
  input wire logic clk_sys,
  output logic inclock,
  output logic outclock,
  output logic inclken,
  output logic outclken,
  output logic wren,
  output logic [emb_pkg::ADDR_W-1:0] wr_addr,
  output logic [emb_pkg::ADDR_W-1:0] rd_addr,
  output logic [emb_pkg::MAX_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import emb_pkg::*;

  initial begin
    inclock = 1'b0;
    outclock = 1'b0;
    inclken = 1'b0;
    outclken = 1'b0;
    wren = 1'b0;
    wr_addr = 11'h000;
    rd_addr = 11'h000;
    data_in = 16'h0000;
  end

  // One inclock pulse; released wr_addr and data_in show the inverse so stale data never looks valid.
  task automatic cap(input logic [10:0] a, input logic [10:0] ra, input logic [15:0] d,
                     input logic we, input logic en);
    @(posedge clk_sys);
    inclock <= 1'b1;
    inclken <= en;
    wren <= we;
    wr_addr <= a;
    rd_addr <= ra;
    data_in <= d;
    @(posedge clk_sys);
    inclock <= 1'b0;
    inclken <= 1'b0;
    wren <= 1'b0;
    wr_addr <= ~a;
    data_in <= ~d;
  endtask

  // One outclock pulse; returns at the edge that samples the rise.
  task automatic oclk(input logic [10:0] ra, input logic en);
    @(posedge clk_sys);
    outclock <= 1'b1;
    outclken <= en;
    rd_addr <= ra;
    @(posedge clk_sys);
    outclock <= 1'b0;
    outclken <= 1'b0;
    rd_addr <= ~ra;
  endtask
endmodule

// File: verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import emb_pkg::*;
  logic clk_sys;
  logic rst = 1'b1;
  logic clr_local = 1'b0;
  logic clr_global = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, inclock, outclock, inclken, outclken, wren, match_out;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [MAX_W-1:0] data_in, data_out;
  int err_count = 0;
  int compares = 0;
  logic [10:0] a;
  logic [15:0] m;

  emb_memory_block #(.LP_EXTRA(LP_EXTRA_DEF)) i_emb_memory_block (.clk_sys(clk_sys),
    .rst(rst), .clr_local(clr_local), .clr_global(clr_global), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inclock(inclock), .outclock(outclock),
    .inclken(inclken), .outclken(outclken), .wren(wren), .wr_addr(wr_addr),
    .rd_addr(rd_addr), .data_in(data_in), .data_out(data_out), .match_out(match_out));
  emb_fabric_model i_emb_fabric_model (.clk_sys(clk_sys), .inclock(inclock),
    .outclock(outclock), .inclken(inclken), .outclken(outclken), .wren(wren),
    .wr_addr(wr_addr), .rd_addr(rd_addr), .data_in(data_in));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task end_of_test;
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_out(input logic [15:0] d, input logic mt);
    compares++;
    if ({data_out, match_out} !== {d, mt}) begin
      err_count++;
      $display("[FAIL] %0t port got %h/%b expected %h/%b", $time, data_out, match_out, d, mt);
    end
  endtask

  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [31:0] exp,
           input logic experr);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      end_of_test();
    end
    chk({31'h0, pslverr}, {31'h0, experr});
    if (!w) chk(prdata, exp);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task cfg(input logic [2:0] md, input logic [2:0] s, input logic lp);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b1, OFS_CTRL, {22'h0, 1'b0, lp, 1'b0, s, 1'b0, md}, 32'h0, 1'b0);
    apb(1'b1, OFS_CFG_DONE, 32'h0000_0001, 32'h0, 1'b0);
  endtask

  task look(input logic [10:0] ra, input logic en, input logic [15:0] d, input logic mt);
    i_emb_fabric_model.oclk(ra, en);
    @(negedge clk_sys);
    chk_out(d, mt);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0, 32'h0000_0200, 1'b0);
    apb(1'b1, 12'h0FC, 32'h0, 32'h0, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h0, 32'h0, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_0005, 32'h0, 1'b1);
    apb(1'b0, OFS_CTRL, 32'h0, 32'h0000_0200, 1'b0);
    apb(1'b1, OFS_CFG_DONE, 32'h0000_0001, 32'h0, 1'b0);
    i_emb_fabric_model.cap(11'h040, 11'h000, 16'h7777, 1'b1, 1'b1);
    look(11'h000, 1'b1, 16'h0000, 1'b0);
    cfg(EMB_SP_RAM, SHAPE_128X16, 1'b0);
    for (int i = 0; i < 128; i++) begin
      i_emb_fabric_model.cap(11'(i), 11'h000, 16'hC000 | 16'(i), 1'b1, 1'b1);
    end
    i_emb_fabric_model.cap(11'h040, 11'h000, 16'h0000, 1'b0, 1'b1);
    look(11'h000, 1'b1, 16'hC040, 1'b0);
    apb(1'b1, OFS_LOAD_ADDR, 32'h0000_0005, 32'h0, 1'b1);
    cfg(EMB_ROM, SHAPE_128X16, 1'b0);
    apb(1'b0, OFS_LOAD_DATA, 32'h0, 32'h0000_C000, 1'b0);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b1, OFS_LOAD_ADDR, 32'h0000_0005, 32'h0, 1'b0);
    apb(1'b1, OFS_LOAD_DATA, 32'h0000_BEEF, 32'h0, 1'b0);
    apb(1'b1, OFS_LOAD_ADDR, 32'h0000_0005, 32'h0, 1'b0);
    apb(1'b0, OFS_LOAD_DATA, 32'h0, 32'h0000_BEEF, 1'b0);
    apb(1'b1, OFS_CTRL, {29'h0, EMB_ROM}, 32'h0, 1'b0);
    apb(1'b1, OFS_CFG_DONE, 32'h0000_0001, 32'h0, 1'b0);
    apb(1'b1, OFS_LOAD_DATA, 32'h0000_1234, 32'h0, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0, 32'h0, 1'b1);
    i_emb_fabric_model.cap(11'h005, 11'h000, 16'h1234, 1'b1, 1'b1);
    look(11'h000, 1'b1, 16'hBEEF, 1'b0);
    for (int s = 0; s < 5; s++) begin
      cfg(EMB_SP_RAM, 3'(s), 1'b0);
      chk_out(16'h0000, 1'b0);
      a = 11'((128 << s) - 1);
      m = 16'((32'h1 << (16 >> s)) - 1);
      i_emb_fabric_model.cap(a - 11'h001, 11'h000, 16'h5A3C, 1'b1, 1'b1);
      i_emb_fabric_model.cap(a, 11'h000, 16'hA5C3, 1'b1, 1'b1);
      look(11'h000, 1'b1, 16'hA5C3 & m, 1'b0);
      i_emb_fabric_model.cap(a - 11'h001, 11'h000, 16'h0000, 1'b0, 1'b1);
      look(11'h000, 1'b1, 16'h5A3C & m, 1'b0);
    end
    cfg(EMB_DP_RW, SHAPE_128X16, 1'b0);
    i_emb_fabric_model.cap(11'h010, 11'h000, 16'h1111, 1'b1, 1'b1);
    i_emb_fabric_model.cap(11'h011, 11'h000, 16'h2222, 1'b1, 1'b1);
    i_emb_fabric_model.cap(11'h030, 11'h000, 16'h2222, 1'b1, 1'b1);
    look(11'h011, 1'b1, 16'h2222, 1'b0);
    look(11'h010, 1'b1, 16'h1111, 1'b0);
    i_emb_fabric_model.cap(11'h010, 11'h000, 16'h3333, 1'b1, 1'b0);
    look(11'h011, 1'b0, 16'h1111, 1'b0);
    look(11'h010, 1'b1, 16'h1111, 1'b0);
    cfg(EMB_DP_IO, SHAPE_128X16, 1'b0);
    i_emb_fabric_model.cap(11'h020, 11'h010, 16'h4444, 1'b1, 1'b1);
    look(11'h7FF, 1'b1, 16'h1111, 1'b0);
    for (int i = 0; i < 3; i++) begin
      i_emb_fabric_model.cap(11'h000, 11'h020, 16'h0000, 1'b0, 1'b1);
      look(11'h7FF, 1'b1, 16'h4444, 1'b0);
      @(posedge clk_sys);
      clr_local <= (i == 0);
      clr_global <= (i == 1);
      rst <= (i == 2);
      @(negedge clk_sys);
      chk_out(16'h0000, 1'b0);
      @(posedge clk_sys);
      clr_local <= 1'b0;
      clr_global <= 1'b0;
      rst <= 1'b0;
    end
    cfg(EMB_CAM, SHAPE_128X16, 1'b0);
    i_emb_fabric_model.cap(11'h000, 11'h000, 16'h2222, 1'b0, 1'b1);
    look(11'h000, 1'b1, 16'h0011, 1'b1);
    i_emb_fabric_model.cap(11'h000, 11'h000, 16'hC07D, 1'b0, 1'b1);
    look(11'h000, 1'b1, 16'h007D, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0, 32'h007D_0003, 1'b0);
    i_emb_fabric_model.cap(11'h000, 11'h000, 16'h0BAD, 1'b0, 1'b1);
    look(11'h000, 1'b1, 16'h0000, 1'b0);
    cfg(EMB_SP_RAM, SHAPE_128X16, 1'b1);
    i_emb_fabric_model.cap(11'h040, 11'h000, 16'h0000, 1'b0, 1'b1);
    look(11'h000, 1'b1, 16'h0000, 1'b0);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk_out(16'h0000, 1'b0);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk_out(16'hC040, 1'b0);
    end_of_test();
  end
endmodule
